// ---- console_link_pkg.sv ----
// Shared constants, types and helpers for the host link record interpreter
// How it works
// (R1) Numeral-to-symbol conversion sends a 3E record with headed parameters, ended by CR.
// (R2) Host stores every character before the CR into its input buffer.
// (R3) With no headed parameter left, host sends 80 text CR, awaits F8, answers F1.
// (R4) A headed parameter found in the host symbol table is replaced by its symbol.
// (R5) A headed parameter without entry loses its header; host keeps scanning.
// (R6) After conversion the host returns an 80 record with symbols, ended by CR.
// (R7) Device sends F8 CR once the symbolic text has been displayed.
// (R8) Host closes the conversion exchange with F1 CR.
// (R9) Each command output line goes to the host as an 80 record ending CR.
// (R10) Host acknowledges each output line with F8 CR after printing or filing it.
// (R11) In local mode with host-on active, print-on is forwarded as illegal command.
// (R12) Local mode offers exactly four console sequences: char/text read and write.
// (R13) Console character read opens with key input request code 8A.
// (R14) With a console key pending, device replies F9, the character, CR.
// (R15) A key forwarded during a character read is not echoed to the console.
// (R16) With no key pending during a character read, device replies F8 CR.
// (R17) Host requests a console line with 88 CR.
// (R18) Device answers a line request with F9, the typed line and CR.
// (R19) At most 255 line characters are forwarded; further typed characters are dropped.
// (R20) Host 82 record: characters go to the console with no CR or LF added.
// (R21) After a raw character output the device sends F8 CR.
// (R22) An 80 line output writes text and CR to the console, then a LF.
// (R23) After a console line output the device sends F8 CR.
// (R24) On the quit record the host returns to its OS; host-on is cancelled.
// (R25) Records open with backslash and two hex digits; the next CR ends them.
package console_link_pkg;

    localparam logic [7:0] CH_BSLASH     = 8'h5c;
    localparam logic [7:0] CH_CR         = 8'h0d;
    localparam logic [7:0] CH_LF         = 8'h0a;

    localparam logic [7:0] CODE_CONV     = 8'h3e;
    localparam logic [7:0] CODE_LINE     = 8'h80;
    localparam logic [7:0] CODE_RAW      = 8'h82;
    localparam logic [7:0] CODE_LINE_REQ = 8'h88;
    localparam logic [7:0] CODE_KEY_REQ  = 8'h8a;
    localparam logic [7:0] CODE_ACK      = 8'hf8;
    localparam logic [7:0] CODE_DATA     = 8'hf9;
    localparam logic [7:0] CODE_END      = 8'hf1;

    localparam logic [7:0] LINE_MAX      = 8'hff;
    localparam logic [1:0] HEAD_LAST     = 2'h2;

    typedef enum logic [1:0] {EV_CODE, EV_DATA, EV_END} ev_kind_e;

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    // Upper bit flags a legal digit; either letter case is taken
    function automatic logic [4:0] hex_value(input logic [7:0] c);
        logic [4:0] r;
        r = 5'h00;
        if (c >= 8'h30 && c <= 8'h39) begin
            r = {1'b1, c[3:0]};
        end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
            r = {1'b1, c[3:0] + 4'h9};
        end
        return r;
    endfunction

endpackage

// ---- link_event_if.sv ----
// Parsed host record events passed from the receiver to the interpreter
`timescale 1ns/1ps
interface link_event_if;
    logic                        valid;
    console_link_pkg::ev_kind_e  kind;
    logic [7:0]                  data;
    logic                        ready;

    modport producer (output valid, output kind, output data, input ready);
    modport consumer (input valid, input kind, input data, output ready);
endinterface

// ---- link_record_rx.sv ----
// Host record receiver: splits incoming bytes into code, data and end events
`timescale 1ns/1ps
module link_record_rx (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             link_rx_valid_i,
    input  wire logic [7:0]       link_rx_data_i,
    output logic                  link_rx_ready_o,
    link_event_if.producer        ev
);
    typedef enum logic [1:0] {HUNT, DIGIT_HI, DIGIT_LO, BODY} rx_state_e;

    typedef struct packed {
        rx_state_e                 state;
        logic [3:0]                hi;
        logic                      valid;
        console_link_pkg::ev_kind_e kind;
        logic [7:0]                data;
    } rx_s;

    rx_s        st;
    rx_s        next_st;
    logic [4:0] digit;

    // One event slot; a new byte is taken when the slot is empty or empties this cycle
    assign link_rx_ready_o = !st.valid || ev.ready;
    assign ev.valid        = st.valid;
    assign ev.kind         = st.kind;
    assign ev.data         = st.data;

    always_comb begin
        next_st = st;
        digit   = console_link_pkg::hex_value(link_rx_data_i);
        if (st.valid && ev.ready) begin
            next_st.valid = 1'b0;
        end
        if (link_rx_valid_i && link_rx_ready_o) begin
            unique case (st.state)
                HUNT: begin
                    // Anything outside a record is discarded until a backslash
                    if (link_rx_data_i == console_link_pkg::CH_BSLASH) begin
                        next_st.state = DIGIT_HI; // R25
                    end
                end
                DIGIT_HI: begin
                    next_st.hi    = digit[3:0];
                    next_st.state = digit[4] ? DIGIT_LO : HUNT; // R25
                end
                DIGIT_LO: begin
                    if (digit[4]) begin
                        next_st.valid = 1'b1;
                        next_st.kind  = console_link_pkg::EV_CODE;
                        next_st.data  = {st.hi, digit[3:0]}; // R25
                        next_st.state = BODY;
                    end else begin
                        next_st.state = HUNT;
                    end
                end
                BODY: begin
                    next_st.valid = 1'b1;
                    next_st.data  = link_rx_data_i;
                    if (link_rx_data_i == console_link_pkg::CH_CR) begin
                        next_st.kind  = console_link_pkg::EV_END; // R25
                        next_st.state = HUNT;
                    end else begin
                        next_st.kind  = console_link_pkg::EV_DATA;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ---- console_link_records.sv ----
// Record interpreter between emulator core, operator console and host link
`timescale 1ns/1ps
module console_link_records (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        link_rx_valid_i,
    input  wire logic [7:0]  link_rx_data_i,
    output logic             link_rx_ready_o,
    output logic             link_tx_valid_o,
    output logic [7:0]       link_tx_data_o,
    input  wire logic        link_tx_ready_i,
    input  wire logic        key_valid_i,
    input  wire logic [7:0]  key_data_i,
    output logic             con_tx_valid_o,
    output logic [7:0]       con_tx_data_o,
    input  wire logic        con_tx_ready_i,
    input  wire logic        core_start_i,
    input  wire logic        core_kind_i,
    input  wire logic        core_valid_i,
    input  wire logic [7:0]  core_data_i,
    input  wire logic        core_last_i,
    output logic             core_ready_o,
    output logic             done_o,
    output logic             busy_o,
    input  wire logic        local_mode_i,
    input  wire logic        host_on_i,
    input  wire logic        print_on_i,
    output logic             print_forward_o,
    output logic             print_local_o
);
    typedef enum logic [3:0] {
        IDLE, WAIT_TEXT, WAIT_ACK, WAIT_END, SKIP, KEY_REPLY, LINE_READ, CON_COPY,
        CON_CR, CON_LF, HEAD, BODY_CORE, BODY_CHAR, BODY_LINE, TAIL, FINISH
    } state_e;

    typedef enum logic [1:0] {B_NONE, B_CORE, B_CHAR, B_LINE} body_e;

    typedef struct packed {
        state_e      state;
        state_e      resume;
        state_e      goal;
        state_e      after;
        body_e       body;
        logic [7:0]  code;
        logic [1:0]  step;
        logic        lf;
        logic [7:0]  idx;
        logic [7:0]  line_len;
        logic        key_valid;
        logic [7:0]  key_byte;
        logic [7:0]  out_char;
        logic        tx_valid;
        logic [7:0]  tx_data;
        logic        con_valid;
        logic [7:0]  con_data;
        logic        done;
        logic        fwd;
        logic        lcl;
    } st_s;

    st_s         st;
    st_s         next_st;
    logic        ev_ready;
    logic        core_ready;
    logic        tx_free;
    logic        con_free;
    logic        mem_we;
    logic [7:0]  line_mem [0:254];
    logic [7:0]  mem_rd;

    link_event_if ev ();

    link_record_rx rx (
        .clock_i         (clock_i),
        .rst_i           (rst_i),
        .link_rx_valid_i (link_rx_valid_i),
        .link_rx_data_i  (link_rx_data_i),
        .link_rx_ready_o (link_rx_ready_o),
        .ev              (ev)
    );

    assign ev.ready = ev_ready;
    assign mem_rd   = line_mem[st.idx];

    // Opens an outgoing record, core or reply; the head, any body (none for B_NONE) and closing CR follow in turn
    function automatic st_s open_record(input st_s s, input logic [7:0] code, input body_e b, input state_e a);
        st_s r;
        r       = s;
        r.code  = code;
        r.body  = b;
        r.after = a;
        r.step  = 2'h0;
        r.idx   = 8'h00;
        r.state = HEAD;
        return r;
    endfunction

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        ev_ready     = 1'b0;
        core_ready   = 1'b0;
        mem_we       = 1'b0;
        tx_free      = !st.tx_valid || link_tx_ready_i;
        con_free     = !st.con_valid || con_tx_ready_i;
        if (st.tx_valid && link_tx_ready_i) begin
            next_st.tx_valid = 1'b0;
        end
        if (st.con_valid && con_tx_ready_i) begin
            next_st.con_valid = 1'b0;
        end
        // Single pending key; further keys are lost until it is taken
        if (key_valid_i && !st.key_valid) begin
            next_st.key_valid = 1'b1;
            next_st.key_byte  = key_data_i;
        end
        next_st.fwd = print_on_i && local_mode_i && host_on_i; // R11
        next_st.lcl = print_on_i && !(local_mode_i && host_on_i);

        unique case (st.state)
            IDLE, WAIT_TEXT, WAIT_ACK, WAIT_END: begin
                // Core start wins over host records in IDLE so its pulse is not lost there; in the WAIT states it is ignored
                if (st.state == IDLE && core_start_i) begin
                    if (core_kind_i) begin
                        next_st = open_record(next_st, console_link_pkg::CODE_CONV, B_CORE, WAIT_TEXT); // R1
                    end else begin
                        next_st = open_record(next_st, console_link_pkg::CODE_LINE, B_CORE, WAIT_ACK); // R9
                    end
                end else if (ev.valid) begin
                    ev_ready       = 1'b1;
                    next_st.resume = st.state;
                    next_st.goal   = st.state;
                    if (ev.kind == console_link_pkg::EV_CODE) begin
                        next_st.state = SKIP;
                        // Console sequences are only served in local mode, except an 80 line that is also taken in WAIT_TEXT
                        if (ev.data == console_link_pkg::CODE_KEY_REQ && local_mode_i) begin
                            next_st.goal = KEY_REPLY; // R12 R13
                        end else if (ev.data == console_link_pkg::CODE_LINE_REQ && local_mode_i) begin
                            next_st.goal     = LINE_READ; // R12
                            next_st.line_len = 8'h00;
                        end else if (ev.data == console_link_pkg::CODE_RAW && local_mode_i) begin
                            next_st.state = CON_COPY; // R12 R20
                            next_st.lf    = 1'b0;
                        end else if (ev.data == console_link_pkg::CODE_LINE
                                     && (local_mode_i || st.state == WAIT_TEXT)) begin
                            next_st.state = CON_COPY; // R12 R22
                            next_st.lf    = 1'b1;
                            if (st.state == WAIT_TEXT) begin
                                next_st.resume = WAIT_END;
                            end
                        end else if (ev.data == console_link_pkg::CODE_ACK && st.state == WAIT_ACK) begin
                            next_st.goal = FINISH; // R10
                        end else if (ev.data == console_link_pkg::CODE_END && st.state == WAIT_END) begin
                            next_st.goal = FINISH; // R8
                        end
                    end
                end
            end
            SKIP: begin
                ev_ready = ev.valid;
                if (ev.valid && ev.kind == console_link_pkg::EV_END) begin
                    next_st.state = st.goal; // R25
                end
            end
            KEY_REPLY: begin
                // The key goes to the host only; nothing is written to the console
                if (st.key_valid) begin
                    // A key typed as the held one leaves takes the freed slot
                    next_st.key_valid = key_valid_i;
                    next_st.key_byte  = key_data_i;
                    next_st.out_char  = st.key_byte;
                    next_st = open_record(next_st, console_link_pkg::CODE_DATA, B_CHAR, st.resume); // R14 R15
                end else begin
                    next_st = open_record(next_st, console_link_pkg::CODE_ACK, B_NONE, st.resume); // R16
                end
            end
            LINE_READ: begin
                if (st.key_valid) begin
                    next_st.key_valid = key_valid_i;
                    next_st.key_byte  = key_data_i;
                    if (st.key_byte == console_link_pkg::CH_CR) begin
                        next_st = open_record(next_st, console_link_pkg::CODE_DATA, B_LINE, st.resume); // R18
                    end else if (st.line_len < console_link_pkg::LINE_MAX) begin
                        mem_we           = 1'b1;
                        next_st.line_len = st.line_len + 8'h01; // R19
                    end
                end
            end
            CON_COPY: begin
                if (ev.valid && ev.kind == console_link_pkg::EV_DATA) begin
                    if (con_free) begin
                        ev_ready          = 1'b1;
                        next_st.con_valid = 1'b1;
                        next_st.con_data  = ev.data; // R20
                    end
                end else if (ev.valid) begin
                    ev_ready = 1'b1;
                    if (st.lf) begin
                        next_st.state = CON_CR; // R22
                    end else begin
                        next_st = open_record(next_st, console_link_pkg::CODE_ACK, B_NONE, st.resume); // R21
                    end
                end
            end
            CON_CR: begin
                if (con_free) begin
                    next_st.con_valid = 1'b1;
                    next_st.con_data  = console_link_pkg::CH_CR; // R22
                    next_st.state     = CON_LF;
                end
            end
            CON_LF: begin
                if (con_free) begin
                    next_st.con_valid = 1'b1;
                    next_st.con_data  = console_link_pkg::CH_LF; // R22
                    next_st = open_record(next_st, console_link_pkg::CODE_ACK, B_NONE, st.resume); // R7 R23
                end
            end
            HEAD: begin
                if (tx_free) begin
                    next_st.tx_valid = 1'b1;
                    next_st.step     = st.step + 2'h1;
                    unique case (st.step)
                        2'h0:    next_st.tx_data = console_link_pkg::CH_BSLASH; // R25
                        2'h1:    next_st.tx_data = console_link_pkg::hex_char(st.code[7:4]);
                        default: next_st.tx_data = console_link_pkg::hex_char(st.code[3:0]);
                    endcase
                    if (st.step == console_link_pkg::HEAD_LAST) begin
                        unique case (st.body)
                            B_NONE: next_st.state = TAIL;
                            B_CORE: next_st.state = BODY_CORE;
                            B_CHAR: next_st.state = BODY_CHAR;
                            B_LINE: next_st.state = BODY_LINE;
                        endcase
                    end
                end
            end
            BODY_CORE: begin
                core_ready = tx_free;
                if (core_valid_i && tx_free) begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_data  = core_data_i; // R1 R9
                    if (core_last_i) begin
                        next_st.state = TAIL;
                    end
                end
            end
            BODY_CHAR: begin
                if (tx_free) begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_data  = st.out_char; // R14
                    next_st.state    = TAIL;
                end
            end
            BODY_LINE: begin
                if (st.idx == st.line_len) begin
                    next_st.state = TAIL;
                end else if (tx_free) begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_data  = mem_rd; // R18
                    next_st.idx      = st.idx + 8'h01;
                end
            end
            TAIL: begin
                if (tx_free) begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_data  = console_link_pkg::CH_CR; // R25
                    next_st.state    = st.after;
                end
            end
            FINISH: begin
                next_st.done  = 1'b1;
                next_st.state = IDLE;
            end
        endcase
    end

    // Line storage has no reset; only the first line_len entries are ever read
    always_ff @(posedge clock_i) begin
        if (mem_we) begin
            line_mem[st.line_len] <= st.key_byte;
        end
    end

    // IDLE is the zero code of the state type
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link_tx_valid_o = st.tx_valid;
    assign link_tx_data_o  = st.tx_data;
    assign con_tx_valid_o  = st.con_valid;
    assign con_tx_data_o   = st.con_data;
    assign core_ready_o    = core_ready;
    assign done_o          = st.done;
    assign busy_o          = st.state != IDLE;
    assign print_forward_o = st.fwd;
    assign print_local_o   = st.lcl;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    a_tx_held_stall: assert property (link_tx_valid_o && !link_tx_ready_i |=> link_tx_valid_o && $stable(link_tx_data_o)) // R25
        else $error("link byte changed while stalled");
    a_conv_code: assert property (st.state == IDLE && core_start_i && core_kind_i |=> st.state == HEAD && st.code == 8'h3e) // R1
        else $error("conversion record not opened with 3E");
    a_cmd_code: assert property (st.state == IDLE && core_start_i && !core_kind_i |=> st.code == 8'h80 && st.after == WAIT_ACK) // R9
        else $error("command output not opened with 80");
    a_no_key_echo: assert property (st.state == KEY_REPLY |=> !(con_tx_valid_o && !$past(con_tx_valid_o))) // R15
        else $error("character read echoed to console");
    a_key_pending_f9: assert property (st.state == KEY_REPLY && st.key_valid |=> st.code == 8'hf9 && st.body == B_CHAR) // R14
        else $error("pending key not answered with F9");
    a_key_absent_f8: assert property (st.state == KEY_REPLY && !st.key_valid |=> st.code == 8'hf8 && st.body == B_NONE) // R16
        else $error("missing key not answered with F8");
    a_line_limit: assert property (st.state == LINE_READ && st.line_len == 8'hff |=> st.line_len == 8'hff) // R19
        else $error("line grew past 255");
    a_print_forward: assert property (print_on_i && local_mode_i && host_on_i |=> print_forward_o && !print_local_o) // R11
        else $error("print-on not forwarded in host-on mode");
    a_lf_follows_cr: assert property (st.state == CON_CR && con_free |=> st.con_data == 8'h0d ##[1:64] st.con_data == 8'h0a) // R22
        else $error("line feed missing after CR");
    a_reply_closes: assert property (st.state == TAIL && tx_free |=> link_tx_data_o == 8'h0d && st.state == $past(st.after)) // R21 R23 R7
        else $error("record not closed with CR");
endmodule

// ---- host_link_model.sv ----
// Host-side link model: sends records to the interpreter and stalls its receive side on demand
`timescale 1ns/1ps
module host_link_model (
    input  wire logic       clock_i,
    input  wire logic       slow_i,
    output logic            tx_valid_o,
    output logic [7:0]      tx_data_o,
    input  wire logic       tx_ready_i,
    output logic            rx_ready_o
);
    logic tick = 1'h0;
    initial begin
        tx_valid_o = 1'h0;
        tx_data_o = 8'h00;
    end
    // Stalls every other cycle when slow, so replies must hold their byte
    assign rx_ready_o = !(slow_i && tick);
    always @(posedge clock_i) tick <= !tick;
    // A record goes out whole: backslash, two hex digits, payload, CR
    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) begin
            tx_valid_o <= 1'h1;
            tx_data_o <= s[i];
            @(posedge clock_i);
            while (!tx_ready_i) @(posedge clock_i);
        end
        tx_valid_o <= 1'h0;
        // Released line shows the inverse, never a stale byte
        tx_data_o <= ~tx_data_o;
    endtask
endmodule

// ---- host_link_console_records_tb.sv ----
// Self-checking bench for the host link record interpreter
`timescale 1ns/1ps
module host_link_console_records_tb;
    logic clock_i, rst_i, link_rx_valid_i, link_rx_ready_o, link_tx_valid_o, link_tx_ready_i, key_valid_i;
    logic con_tx_valid_o, core_start_i, core_kind_i, core_valid_i, core_last_i, core_ready_o, done_o, busy_o;
    logic local_mode_i, host_on_i, print_on_i, print_forward_o, print_local_o, slow;
    logic [7:0] link_rx_data_i, link_tx_data_o, key_data_i, con_tx_data_o, core_data_i;
    logic [7:0] host_q[$], con_q[$];
    int mismatches, total_checks, dones;
    console_link_records i_console_link_records (
        .clock_i(clock_i), .rst_i(rst_i), .link_rx_valid_i(link_rx_valid_i), .link_rx_data_i(link_rx_data_i),
        .link_rx_ready_o(link_rx_ready_o), .link_tx_valid_o(link_tx_valid_o), .link_tx_data_o(link_tx_data_o),
        .link_tx_ready_i(link_tx_ready_i), .key_valid_i(key_valid_i), .key_data_i(key_data_i),
        .con_tx_valid_o(con_tx_valid_o), .con_tx_data_o(con_tx_data_o), .con_tx_ready_i(link_tx_ready_i),
        .core_start_i(core_start_i), .core_kind_i(core_kind_i), .core_valid_i(core_valid_i), .core_data_i(core_data_i),
        .core_last_i(core_last_i), .core_ready_o(core_ready_o), .done_o(done_o), .busy_o(busy_o),
        .local_mode_i(local_mode_i), .host_on_i(host_on_i), .print_on_i(print_on_i),
        .print_forward_o(print_forward_o), .print_local_o(print_local_o));
    host_link_model i_host_link_model (.clock_i(clock_i), .slow_i(slow), .tx_valid_o(link_rx_valid_i),
        .tx_data_o(link_rx_data_i), .tx_ready_i(link_rx_ready_o), .rx_ready_o(link_tx_ready_i));
    initial begin
        clock_i = 1'h0;
        forever #2 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (link_tx_valid_o && link_tx_ready_i) host_q.push_back(link_tx_data_o);
        if (con_tx_valid_o && link_tx_ready_i) con_q.push_back(con_tx_data_o);
        if (done_o === 1'h1) dones++;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Waits a bounded time for the bytes, then compares and empties the queue
    task automatic expect_bytes(input string nm, ref logic [7:0] q[$], input string exp);
        for (int n = 0; q.size() < exp.len() && n < 3000; n++) @(posedge clock_i);
        repeat (6) @(posedge clock_i);
        for (int i = 0; i < exp.len(); i++) chk(nm, exp[i], q[i]);
        chk({nm, " count"}, exp.len(), q.size());
        q.delete();
    endtask
    task automatic host_send(input string s);
        i_host_link_model.send(s);
    endtask
    task automatic key(input logic [7:0] b);
        key_valid_i <= 1'h1;
        key_data_i <= b;
        @(posedge clock_i);
        key_valid_i <= 1'h0;
        @(posedge clock_i);
    endtask
    task automatic t_write;
        host_send("\\82A\015");
        expect_bytes("raw out", con_q, "A");
        expect_bytes("raw ack", host_q, "\\F8\015");
        host_send("\\80B\015");
        expect_bytes("line out", con_q, "B\015\012");
        expect_bytes("line ack", host_q, "\\F8\015");
    endtask
    task automatic t_key;
        host_send("\\8A\015");
        expect_bytes("no key", host_q, "\\F8\015");
        key(8'h4b);
        host_send("\\8A\015");
        expect_bytes("key read", host_q, "\\F9K\015");
        expect_bytes("key echo", con_q, "");
    endtask
    task automatic t_line;
        string s;
        s = "\\F9";
        host_send("\\88\015");
        repeat (8) @(posedge clock_i);
        // Overlong line: only the first 255 keys may reach the host
        for (int i = 0; i < 300; i++) key(8'h78);
        key(8'h0d);
        for (int i = 0; i < 255; i++) s = {s, "x"};
        expect_bytes("line read", host_q, {s, "\015"});
    endtask
    task automatic t_core(input logic kind, input string hd);
        int d;
        d = dones;
        core_start_i <= 1'h1;
        core_kind_i <= kind;
        @(posedge clock_i);
        core_start_i <= 1'h0;
        core_valid_i <= 1'h1;
        core_data_i <= 8'h58;
        core_last_i <= 1'h1;
        @(posedge clock_i);
        while (!core_ready_o) @(posedge clock_i);
        core_valid_i <= 1'h0;
        core_last_i <= 1'h0;
        expect_bytes("core rec", host_q, {hd, "X\015"});
        if (kind) begin
            host_send("\\80Q\015");
            expect_bytes("sym text", con_q, "Q\015\012");
            expect_bytes("sym ack", host_q, "\\F8\015");
        end
        host_send(kind ? "\\F1\015" : "\\F8\015");
        repeat (6) @(posedge clock_i);
        chk("done", d + 1, dones);
    endtask
    task automatic t_print(input logic on);
        host_on_i <= on;
        print_on_i <= 1'h1;
        @(posedge clock_i);
        print_on_i <= 1'h0;
        #1;
        chk("print fwd", on, print_forward_o);
        chk("print local", !on, print_local_o);
        @(posedge clock_i);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clock_i);
        mismatches++;
        results();
    end
    initial begin
        rst_i = 1'h1;
        {key_valid_i, core_start_i, core_kind_i, core_valid_i, core_last_i, print_on_i, host_on_i, slow} = '0;
        {local_mode_i, key_data_i, core_data_i} = '0;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'h0;
        @(posedge clock_i);
        chk("idle busy", 0, busy_o);
        // Console write outside local mode must be swallowed silently
        host_send("\\82A\015");
        expect_bytes("remote out", con_q, "");
        expect_bytes("remote ack", host_q, "");
        local_mode_i <= 1'h1;
        @(posedge clock_i);
        t_write();
        t_key();
        t_line();
        t_core(1'h0, "\\80");
        slow <= 1'h1;
        t_core(1'h1, "\\3E");
        t_print(1'h1);
        t_print(1'h0);
        results();
    end
endmodule
